// >>> shared/mcms_map.svh
// Constants of the channel-enable and misc-settings request handler.
// Included by mcms_top; holds definitions only.
`ifndef MCMS_MAP_SVH
`define MCMS_MAP_SVH

// Function, exception and sub-function codes
`define MCMS_FUNC_MISC 8'h46
`define MCMS_FUNC_EXC 8'hC6
`define MCMS_EXC_RANGE 8'h03
`define MCMS_SUB_RD_CHEN 8'h25
`define MCMS_SUB_WR_CHEN 8'h26
`define MCMS_SUB_RD_MISC 8'h29
`define MCMS_SUB_WR_MISC 8'h2A
`define MCMS_SET_OK 8'h00

// Field limits
`define MCMS_CHEN_MAX 8'h3F
`define MCMS_MISC_FILT_BIT 7
`define MCMS_MISC_RSVD_MASK 8'h7F
`define MCMS_ADDR_MIN 8'h01
`define MCMS_ADDR_MAX 8'hF7

// Frame lengths in bytes
`define MCMS_LEN_READ 4'h3
`define MCMS_LEN_SET 4'h4
`define MCMS_LEN_RESP 4'h4
`define MCMS_LEN_EXC 4'h3

// Register offsets
`define MCMS_REG_CFG 4'h0
`define MCMS_REG_STAT 4'h4
`define MCMS_REG_REQCNT 4'h8
`define MCMS_REG_EXCCNT 4'hC

// Register fields and reset values
`define MCMS_CFG_LEGACY_BIT 8
`define MCMS_STAT_FILT_BIT 8
`define MCMS_STAT_BUSY_BIT 9
`define MCMS_CFG_ADDR_RST 8'h01
`define MCMS_CHEN_RST 6'h3F
`define MCMS_FILT_RST 1'b0

`endif

// >>> shared/mcms_pkg.sv
// Types of the channel-enable and misc-settings request handler.
// Assumes nothing of its surroundings.
package mcms_pkg;

  typedef logic [7:0] mcms_byte_t;

  typedef enum logic [1:0] {
    MCMS_IDLE = 2'b00,
    MCMS_EVAL = 2'b01,
    MCMS_SEND = 2'b11
  } mcms_state_t;

endpackage

// >>> rtl/mcms_rx_frame.sv
// Collects one request frame byte by byte and reports its length.
// Assumes a framing layer on the same clock that ends each frame
// with a one-cycle end pulse after the last byte.
`timescale 1ns/1ps
module mcms_rx_frame #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Byte stream
  input wire logic i_rx_valid,
  input wire mcms_pkg::mcms_byte_t i_rx_data,
  input wire logic i_rx_end,
  // Collected frame
  output logic o_done,
  output logic [3:0] o_len,
  output logic [8*DEPTH-1:0] o_bytes
);
  import mcms_pkg::*;

  logic [3:0] cnt_q;
  logic [7:0] buf_q [0:DEPTH-1];

  ////////////////////////////////////////////////////////////////////
  // Byte count, saturating so that long frames still read as wrong
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
    end else if (i_rx_end) begin
      cnt_q <= 4'h0;
    end else if (i_rx_valid && cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      o_len <= 4'h0;
    end else begin
      o_done <= i_rx_end;
      if (i_rx_end) begin
        o_len <= cnt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Storage of the leading bytes
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_buf
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          buf_q[g] <= 8'h00;
        end else if (i_rx_valid && cnt_q == 4'(g)) begin
          buf_q[g] <= i_rx_data;
        end
      end
      assign o_bytes[8*g +: 8] = buf_q[g];
    end
  endgenerate

endmodule

// >>> rtl/mcms_tx_ser.sv
// Sends a reply of up to four bytes, low byte first, with handshake.
// Assumes the sink takes a byte in each cycle with valid and ready.
`timescale 1ns/1ps
module mcms_tx_ser (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Load
  input wire logic i_start,
  input wire logic [31:0] i_bytes,
  input wire logic [3:0] i_len,
  // Byte stream
  input wire logic i_ready,
  output logic o_valid,
  output mcms_pkg::mcms_byte_t o_data,
  output logic o_last
);
  import mcms_pkg::*;

  logic [31:0] sh_q;
  logic [3:0] left_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 32'h0000_0000;
      left_q <= 4'h0;
      o_valid <= 1'b0;
      o_data <= 8'h00;
      o_last <= 1'b0;
    end else if (i_start) begin
      sh_q <= i_bytes;
      left_q <= i_len;
      o_valid <= 1'b1;
      o_data <= i_bytes[7:0];
      o_last <= (i_len == 4'h1);
    end else if (o_valid && i_ready) begin
      if (left_q == 4'h1) begin
        o_valid <= 1'b0;
        o_last <= 1'b0;
        left_q <= 4'h0;
      end else begin
        sh_q <= {8'h00, sh_q[31:8]};
        o_data <= sh_q[15:8];
        left_q <= left_q - 4'h1;
        o_last <= (left_q == 4'h2);
      end
    end
  end

endmodule

// >>> rtl/mcms_top.sv
// Handler for the channel-enable and misc-settings sub-functions of
// function 46h in a six-channel analog input slave.
// Assumes a framing layer on the same clock that checks the CRC and
// delivers request bytes, and that sends the reply bytes out.
//
// Summary of operation
// - A read-enable request (sub 25h) answers with the enable mask in byte 3.
// - Bit n of the enable mask stands for analog channel n, bit 0 first.
// - A mask bit of one enables its channel and zero disables it.
// - A new mask above 3Fh is refused with exception C6h, code 03.
// - A read request of the wrong length gets exception C6h, code 03.
// - A misc read (sub 29h) echoes address, function, sub and the byte.
// - Misc bit 7 picks the filter: zero for 60 Hz, one for 50 Hz.
// - On older firmware the filter bit is reserved and has no effect.
// - Misc bits 6 to 0 are reserved and always read back as zero.
// - A misc write with a reserved bit set or wrong length gets C6h/03.
// - A good set request is echoed with zero in byte 3.
// - Each reply repeats the request's slave address in byte 0.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "mcms_map.svh"
module mcms_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Request byte stream
  input wire logic I_RX_VALID,
  input wire mcms_pkg::mcms_byte_t I_RX_DATA,
  input wire logic I_RX_END,
  // Reply byte stream
  input wire logic I_TX_READY,
  output logic O_TX_VALID,
  output mcms_pkg::mcms_byte_t O_TX_DATA,
  output logic O_TX_LAST,
  // Register port
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Settings to the analog front end
  output logic [5:0] O_CH_EN,
  output logic O_FILT_50HZ
);
  import mcms_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations

  mcms_state_t state_q;
  mcms_state_t state_d;

  logic rx_done;
  logic [3:0] rx_len;
  logic [31:0] rx_bytes;

  logic tx_valid;
  logic tx_last;
  mcms_byte_t tx_data;

  logic [7:0] slave_addr_q;
  logic legacy_q;
  logic [5:0] chen_q;
  logic filt_q;
  logic [15:0] req_cnt_q;
  logic [15:0] exc_cnt_q;

  mcms_byte_t req_addr;
  mcms_byte_t req_func;
  mcms_byte_t req_sub;
  mcms_byte_t req_data;

  logic addr_hit;
  logic is_rd_chen;
  logic is_wr_chen;
  logic is_rd_misc;
  logic is_wr_misc;
  logic len_read_ok;
  logic len_set_ok;
  logic chen_ok;
  logic misc_ok;
  logic misc_filt;

  logic reply;
  logic exc;
  logic apply_chen;
  logic apply_filt;
  logic [31:0] resp_bytes;
  logic [3:0] resp_len;
  logic start_q;
  logic [31:0] start_bytes_q;
  logic [3:0] start_len_q;

  ////////////////////////////////////////////////////////////////////
  // Request collection and reply sending

  mcms_rx_frame #(
    .DEPTH(4)
  ) u_rx (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_rx_valid(I_RX_VALID),
    .i_rx_data(I_RX_DATA),
    .i_rx_end(I_RX_END),
    .o_done(rx_done),
    .o_len(rx_len),
    .o_bytes(rx_bytes)
  );

  mcms_tx_ser u_tx (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_start(start_q),
    .i_bytes(start_bytes_q),
    .i_len(start_len_q),
    .i_ready(I_TX_READY),
    .o_valid(tx_valid),
    .o_data(tx_data),
    .o_last(tx_last)
  );

  assign O_TX_VALID = tx_valid;
  assign O_TX_DATA = tx_data;
  assign O_TX_LAST = tx_last;

  ////////////////////////////////////////////////////////////////////
  // Request decode

  assign req_addr = rx_bytes[7:0];
  assign req_func = rx_bytes[15:8];
  assign req_sub = rx_bytes[23:16];
  assign req_data = rx_bytes[31:24];

  // Broadcast and out-of-range addresses never match
  assign addr_hit = (req_addr == slave_addr_q) &&
                    (req_addr >= `MCMS_ADDR_MIN) &&
                    (req_addr <= `MCMS_ADDR_MAX);

  assign is_rd_chen = (req_func == `MCMS_FUNC_MISC) &&
                      (req_sub == `MCMS_SUB_RD_CHEN);
  assign is_wr_chen = (req_func == `MCMS_FUNC_MISC) &&
                      (req_sub == `MCMS_SUB_WR_CHEN);
  assign is_rd_misc = (req_func == `MCMS_FUNC_MISC) &&
                      (req_sub == `MCMS_SUB_RD_MISC);
  assign is_wr_misc = (req_func == `MCMS_FUNC_MISC) &&
                      (req_sub == `MCMS_SUB_WR_MISC);

  assign len_read_ok = (rx_len == `MCMS_LEN_READ);
  assign len_set_ok = (rx_len == `MCMS_LEN_SET);
  assign chen_ok = len_set_ok && (req_data <= `MCMS_CHEN_MAX);
  assign misc_ok = len_set_ok &&
                   ((req_data & `MCMS_MISC_RSVD_MASK) == 8'h00);

  // Reported filter bit reads as zero while it is reserved
  assign misc_filt = filt_q & ~legacy_q;

  ////////////////////////////////////////////////////////////////////
  // Reply build

  always_comb begin
    reply = 1'b0;
    exc = 1'b0;
    apply_chen = 1'b0;
    apply_filt = 1'b0;
    resp_len = `MCMS_LEN_RESP;
    resp_bytes = {`MCMS_SET_OK, req_sub, req_func, req_addr};
    if (addr_hit) begin
      if (is_rd_chen) begin
        reply = 1'b1;
        if (len_read_ok) begin
          resp_bytes[31:24] = {2'b00, chen_q};
        end else begin
          exc = 1'b1;
        end
      end else if (is_wr_chen) begin
        reply = 1'b1;
        if (chen_ok) begin
          apply_chen = 1'b1;
        end else begin
          exc = 1'b1;
        end
      end else if (is_rd_misc) begin
        reply = 1'b1;
        if (len_read_ok) begin
          resp_bytes[31:24] = {misc_filt, 7'h00};
        end else begin
          exc = 1'b1;
        end
      end else if (is_wr_misc) begin
        reply = 1'b1;
        if (misc_ok) begin
          apply_filt = ~legacy_q;
        end else begin
          exc = 1'b1;
        end
      end
    end
    if (exc) begin
      resp_len = `MCMS_LEN_EXC;
      resp_bytes = {8'h00, `MCMS_EXC_RANGE, `MCMS_FUNC_EXC, req_addr};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      MCMS_IDLE: begin
        if (rx_done) begin
          state_d = MCMS_EVAL;
        end
      end
      MCMS_EVAL: begin
        state_d = reply ? MCMS_SEND : MCMS_IDLE;
      end
      MCMS_SEND: begin
        if (tx_valid && I_TX_READY && tx_last) begin
          state_d = MCMS_IDLE;
        end
      end
      default: begin
        state_d = MCMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= MCMS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Reply load, one cycle after evaluation
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_q <= 1'b0;
      start_bytes_q <= 32'h0000_0000;
      start_len_q <= 4'h0;
    end else begin
      start_q <= (state_q == MCMS_EVAL) && reply;
      if (state_q == MCMS_EVAL) begin
        start_bytes_q <= resp_bytes;
        start_len_q <= resp_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Channel enable and filter settings

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      chen_q <= `MCMS_CHEN_RST;
    end else if (state_q == MCMS_EVAL && apply_chen) begin
      chen_q <= req_data[5:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      filt_q <= `MCMS_FILT_RST;
    end else if (state_q == MCMS_EVAL && apply_filt) begin
      filt_q <= req_data[`MCMS_MISC_FILT_BIT];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CH_EN <= `MCMS_CHEN_RST;
      O_FILT_50HZ <= `MCMS_FILT_RST;
    end else begin
      O_CH_EN <= chen_q;
      O_FILT_50HZ <= misc_filt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      slave_addr_q <= `MCMS_CFG_ADDR_RST;
      legacy_q <= 1'b0;
    end else if (I_REG_WR && I_REG_ADDR == `MCMS_REG_CFG) begin
      slave_addr_q <= I_REG_WDATA[7:0];
      legacy_q <= I_REG_WDATA[`MCMS_CFG_LEGACY_BIT];
    end
  end

  // Counters: a write clears, a same-cycle event still counts
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      req_cnt_q <= 16'h0000;
    end else if (state_q == MCMS_EVAL && reply && !exc) begin
      if (I_REG_WR && I_REG_ADDR == `MCMS_REG_REQCNT) begin
        req_cnt_q <= 16'h0001;
      end else begin
        req_cnt_q <= req_cnt_q + 16'h0001;
      end
    end else if (I_REG_WR && I_REG_ADDR == `MCMS_REG_REQCNT) begin
      req_cnt_q <= 16'h0000;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      exc_cnt_q <= 16'h0000;
    end else if (state_q == MCMS_EVAL && reply && exc) begin
      if (I_REG_WR && I_REG_ADDR == `MCMS_REG_EXCCNT) begin
        exc_cnt_q <= 16'h0001;
      end else begin
        exc_cnt_q <= exc_cnt_q + 16'h0001;
      end
    end else if (I_REG_WR && I_REG_ADDR == `MCMS_REG_EXCCNT) begin
      exc_cnt_q <= 16'h0000;
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `MCMS_REG_CFG: begin
          O_REG_RDATA <= {23'h000000, legacy_q, slave_addr_q};
        end
        `MCMS_REG_STAT: begin
          O_REG_RDATA <= {22'h000000, (state_q != MCMS_IDLE),
                          misc_filt, 2'b00, chen_q};
        end
        `MCMS_REG_REQCNT: begin
          O_REG_RDATA <= {16'h0000, req_cnt_q};
        end
        `MCMS_REG_EXCCNT: begin
          O_REG_RDATA <= {16'h0000, exc_cnt_q};
        end
        default: begin
          O_REG_RDATA <= 32'h0000_0000;
        end
      endcase
    end else begin
      O_REG_RDATA <= 32'h0000_0000;
    end
  end

endmodule

// >>> tb/mcms_top_asserts.sv
// Checker of the reply stream and settings of the request handler.
// Bound to mcms_top; it sees that module's ports only.
`timescale 1ns/1ps
module mcms_top_asserts (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Streams
  input wire logic I_RX_END,
  input wire logic I_TX_READY,
  input wire logic O_TX_VALID,
  input wire mcms_pkg::mcms_byte_t O_TX_DATA,
  input wire logic O_TX_LAST,
  // Register port and settings
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic [5:0] O_CH_EN,
  input wire logic O_FILT_50HZ
);
  import mcms_pkg::*;
  logic [1:0] idx_q;
  mcms_byte_t fn_q;
  mcms_byte_t sub_q;
  logic leg_q;
  logic fin;
  // Final byte of a normal four-byte reply
  assign fin = O_TX_VALID && O_TX_LAST && idx_q == 2'h3 && fn_q == 8'h46;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      idx_q <= 2'h0;
      fn_q <= 8'h00;
      sub_q <= 8'h00;
    end else if (O_TX_VALID && I_TX_READY) begin
      idx_q <= O_TX_LAST ? 2'h0 : idx_q + 2'h1;
      if (idx_q == 2'h1) fn_q <= O_TX_DATA;
      if (idx_q == 2'h2) sub_q <= O_TX_DATA;
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) leg_q <= 1'b0;
    else if (I_REG_WR && I_REG_ADDR == 4'h0) leg_q <= I_REG_WDATA[8];
  end
  //////////////////////////////////////////////////////////////////////
  a_chen_report: assert property (
    fin && sub_q == 8'h25 |-> O_TX_DATA == {2'b00, O_CH_EN})
    else $error("mask reply differs from enable output");
  a_misc_resv: assert property (
    fin && sub_q == 8'h29 |-> O_TX_DATA[6:0] == 7'h00)
    else $error("reserved misc bits not zero");
  a_misc_filt: assert property (
    fin && sub_q == 8'h29 |-> O_TX_DATA[7] == O_FILT_50HZ)
    else $error("misc reply differs from filter output");
  a_set_ok: assert property (
    fin && (sub_q == 8'h26 || sub_q == 8'h2A) |-> O_TX_DATA == 8'h00)
    else $error("set reply byte 3 not zero");
  a_exc_code: assert property (
    O_TX_VALID && idx_q == 2'h2 && fn_q == 8'hC6
    |-> O_TX_DATA == 8'h03 && O_TX_LAST)
    else $error("exception reply malformed");
  a_legacy_filt: assert property (
    leg_q && $past(leg_q) |-> !O_FILT_50HZ)
    else $error("filter applied in legacy mode");
  a_reply_cause: assert property (
    $rose(O_TX_VALID) |-> $past(I_RX_END, 4))
    else $error("reply not four cycles after frame end");
  a_byte_hold: assert property (
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
    else $error("reply byte dropped before taken");
endmodule
bind mcms_top mcms_top_asserts u_chk (
  .I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N),
  .I_RX_END(I_RX_END),
  .I_TX_READY(I_TX_READY),
  .O_TX_VALID(O_TX_VALID),
  .O_TX_DATA(O_TX_DATA),
  .O_TX_LAST(O_TX_LAST),
  .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WDATA(I_REG_WDATA),
  .I_REG_WR(I_REG_WR),
  .O_CH_EN(O_CH_EN),
  .O_FILT_50HZ(O_FILT_50HZ)
);

// >>> tb/mcms_host_model.sv
// Master model on the request and reply byte streams.
// Runs on the handler's clock; one request in flight at a time.
`timescale 1ns/1ps
module mcms_host_model (
  // Clock
  input wire logic i_clk,
  // Reply stream
  input wire logic i_tx_valid,
  input wire mcms_pkg::mcms_byte_t i_tx_data,
  input wire logic i_tx_last,
  // Request stream and reply ready
  output logic o_rx_valid,
  output mcms_pkg::mcms_byte_t o_rx_data,
  output logic o_rx_end,
  output logic o_tx_ready
);
  import mcms_pkg::*;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_rx_end = 1'b0;
    o_tx_ready = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // Sends n bytes from the top of rq, then gathers the reply
  task automatic xfer(input logic [31:0] rq, input int n, input bit slow,
    output logic [31:0] rp, output int rn);
    int w;
    bit done;
    rp = 32'h0;
    rn = 0;
    w = 0;
    done = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= rq[31-8*i -: 8];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    // Idle line must not keep showing the last byte
    o_rx_data <= ~o_rx_data;
    o_rx_end <= 1'b1;
    @(posedge i_clk);
    o_rx_end <= 1'b0;
    o_tx_ready <= !slow;
    while (!done && w < 40) begin
      @(posedge i_clk);
      w++;
      if (i_tx_valid && o_tx_ready) begin
        rp[31-8*rn -: 8] = i_tx_data;
        rn++;
        done = i_tx_last || rn == 4;
      end
      o_tx_ready <= (done || w == 40) ? 1'b0 : (slow ? !o_tx_ready : 1'b1);
    end
  endtask
endmodule

// >>> tb/tb_mcms_top.sv
// Self-checking bench of the request handler.
// Host model is the master; the checker comes in by bind.
`timescale 1ns/1ps
module tb_mcms_top;
  import mcms_pkg::*;
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic I_RX_VALID, I_RX_END, I_TX_READY;
  logic O_TX_VALID, O_TX_LAST, O_FILT_50HZ;
  mcms_byte_t I_RX_DATA, O_TX_DATA;
  logic [3:0] I_REG_ADDR = 4'h0;
  logic [31:0] I_REG_WDATA = 32'h0;
  logic [31:0] O_REG_RDATA;
  logic I_REG_WR = 1'b0;
  logic I_REG_RD = 1'b0;
  logic [5:0] O_CH_EN;
  localparam logic [31:0] exc_rsp = 32'h01C60300;
  int failures = 0;
  int tests_run = 0;
  always #2.5 I_MCLK = ~I_MCLK;
  mcms_top dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .I_RX_VALID(I_RX_VALID), .I_RX_DATA(I_RX_DATA), .I_RX_END(I_RX_END),
    .I_TX_READY(I_TX_READY), .O_TX_VALID(O_TX_VALID),
    .O_TX_DATA(O_TX_DATA), .O_TX_LAST(O_TX_LAST),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .O_CH_EN(O_CH_EN), .O_FILT_50HZ(O_FILT_50HZ));
  mcms_host_model u_host (.i_clk(I_MCLK), .i_tx_valid(O_TX_VALID),
    .i_tx_data(O_TX_DATA), .i_tx_last(O_TX_LAST),
    .o_rx_valid(I_RX_VALID), .o_rx_data(I_RX_DATA),
    .o_rx_end(I_RX_END), .o_tx_ready(I_TX_READY));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_REG_WR <= 1'b1;
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    @(posedge I_MCLK);
    I_REG_WR <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge I_MCLK);
    I_REG_RD <= 1'b1;
    I_REG_ADDR <= a;
    @(posedge I_MCLK);
    I_REG_RD <= 1'b0;
    #1 chk(O_REG_RDATA, exp);
  endtask
  // One request and the reply it must draw
  task automatic run(input logic [31:0] rq, input int n, input bit sl,
    input logic [31:0] ex, input int en);
    logic [31:0] rp;
    int rn;
    u_host.xfer(rq, n, sl, rp, rn);
    chk(32'(rn), 32'(en));
    chk(rp, ex);
  endtask
  // Filter output over enable mask
  task automatic st(input logic [6:0] e);
    chk({25'h0, O_FILT_50HZ, O_CH_EN}, {25'h0, e});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge I_MCLK);
    #1 st(7'h3F);
    chk({31'h0, O_TX_VALID}, 32'h0);
    chk(O_REG_RDATA, 32'h0);
    $display("TEST reset done");
  endtask
  task automatic t_mask();
    run(32'h01462500, 3, 0, 32'h0146253F, 4);
    run(32'h01462615, 4, 1, 32'h01462600, 4);
    st(7'h15);
    run(32'h01462500, 3, 1, 32'h01462515, 4);
    run(32'h01462640, 4, 0, exc_rsp, 3);
    st(7'h15);
    run(32'h0146263F, 4, 0, 32'h01462600, 4);
    st(7'h3F);
    $display("TEST mask done");
  endtask
  task automatic t_len();
    run(32'h01462500, 4, 0, exc_rsp, 3);
    run(32'h01462900, 4, 1, exc_rsp, 3);
    run(32'h01462A00, 3, 0, exc_rsp, 3);
    run(32'h01462600, 3, 0, exc_rsp, 3);
    $display("TEST length done");
  endtask
  task automatic t_misc();
    run(32'h01462A80, 4, 0, 32'h01462A00, 4);
    st(7'h7F);
    run(32'h01462900, 3, 1, 32'h01462980, 4);
    run(32'h01462A81, 4, 0, exc_rsp, 3);
    st(7'h7F);
    run(32'h01462A00, 4, 0, 32'h01462A00, 4);
    st(7'h3F);
    $display("TEST misc done");
  endtask
  task automatic t_legacy();
    // Filter on first, so that legacy mode has something to mask
    run(32'h01462A80, 4, 0, 32'h01462A00, 4);
    reg_wr(4'h0, 32'h101);
    run(32'h01462A00, 4, 0, 32'h01462A00, 4);
    st(7'h3F);
    run(32'h01462900, 3, 0, 32'h01462900, 4);
    reg_wr(4'h0, 32'h1);
    // The write made in legacy mode must not have cleared the filter
    run(32'h01462900, 3, 1, 32'h01462980, 4);
    run(32'h01462A00, 4, 0, 32'h01462A00, 4);
    st(7'h3F);
    $display("TEST legacy done");
  endtask
  task automatic t_addr();
    reg_wr(4'h0, 32'h22);
    run(32'h01462500, 3, 0, 32'h0, 0);
    run(32'h00462500, 3, 0, 32'h0, 0);
    run(32'h22032500, 3, 0, 32'h0, 0);
    run(32'h22462500, 3, 1, 32'h2246253F, 4);
    reg_rd(4'h0, 32'h22);
    reg_wr(4'h0, 32'h1);
    $display("TEST address done");
  endtask
  task automatic t_regs();
    reg_rd(4'h4, 32'h3F);
    reg_rd(4'h2, 32'h0);
    reg_rd(4'h0, 32'h1);
    // Thirteen normal and six exception replies so far
    reg_rd(4'h8, 32'hD);
    reg_rd(4'hC, 32'h6);
    reg_wr(4'h8, 32'h0);
    reg_wr(4'hC, 32'h0);
    reg_rd(4'h8, 32'h0);
    reg_rd(4'hC, 32'h0);
    $display("TEST registers done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    t_reset();
    t_mask();
    t_len();
    t_misc();
    t_legacy();
    t_addr();
    t_regs();
    summarize();
  end
  // Twenty-two requests of under sixty cycles each
  initial begin
    repeat (20000) @(posedge I_MCLK);
    failures++;
    summarize();
  end
endmodule
